// ===== logic/lan_coproc_defines.svh
`ifndef LAN_COPROC_DEFINES_SVH
`define LAN_COPROC_DEFINES_SVH

// reset handling, in system clock cycles
`define LC_RESET_HOLD_CYC      4
`define LC_RESET_DONE_MAX_CYC  10
// serial clock falling edges an input must stay asserted to be accepted
`define LC_ACCEPT_EDGES        2'h2
// framing
`define LC_PREAMBLE_BYTES      4'h8
`define LC_PREAMBLE_BYTE       8'h55
`define LC_SFD_BYTE            8'hd5
// active-low cycle status codes {s1_n, s0_n}
`define LC_STAT_READ           2'h1
`define LC_STAT_WRITE          2'h2
`define LC_STAT_PASSIVE        2'h3
// bus cycles allowed to leave after a withdrawn grant
`define LC_GRANT_LOSS_MAX      3
// line levels at rest
`define LC_TXD_IDLE            1'h1
`define LC_RTS_N_IDLE          1'h1

`endif

// ===== logic/lan_coproc_pkg.sv
package lan_coproc_pkg;

   // local bus sequencer: request, t1..t4, release
   typedef enum logic [2:0] {
      B_IDLE,
      B_REQ,
      B_T1,
      B_T2,
      B_T3,
      B_T4,
      B_REL
   } bus_state_e;

   // transmit serial unit
   typedef enum logic [2:0] {
      TX_IDLE,
      TX_PRE,
      TX_DATA,
      TX_TAIL,
      TX_DROP
   } tx_state_e;

endpackage

// ===== logic/word_fifo.sv
`timescale 1ns/1ps

module word_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic [WIDTH-1:0]      out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
      logic                        rdy;
      logic                        val;
   } fifo_s;

   localparam fifo_s RST_VAL = '{mem: '0, wr: '0, rd: '0, cnt: '0,
                                 rdy: 1'h1, val: 1'h0};

   fifo_s r_r;
   fifo_s r_nxt;
   logic  push;
   logic  pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'h1);
   endfunction

   // ready and valid are flags of their own so the ports come from flops
   always_comb
   begin
      r_nxt = r_r;
      push  = in_valid_i & r_r.rdy;
      pop   = out_ready_i & r_r.val;
      if (push)
      begin
         r_nxt.mem[r_r.wr] = in_data_i;
         r_nxt.wr          = bump(r_r.wr);
      end
      if (pop)
         r_nxt.rd = bump(r_r.rd);
      if (push && !pop)
         r_nxt.cnt = (AW+1)'(r_r.cnt + 1'h1);
      else if (pop && !push)
         r_nxt.cnt = (AW+1)'(r_r.cnt - 1'h1);
      r_nxt.rdy = (r_nxt.cnt != (AW+1)'(DEPTH));
      r_nxt.val = (r_nxt.cnt != '0);
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         r_r <= RST_VAL;
      else
         r_r <= r_nxt;
   end

   assign in_ready_o  = r_r.rdy;
   assign out_valid_o = r_r.val;
   assign out_data_o  = r_r.mem[r_r.rd];

endmodule // word_fifo

// ===== logic/lan_coproc_pins.sv
// What this block does
// - reset input aborts all but the transmit queue; held four clocks
// - reset action finished within ten clocks
// - after reset, idle until first channel attention
// - serial transmit output rests high
// - transmit bits change on transmit clock fall
// - receive bits sampled on receive clock fall
// - transmit request low only while sending
// - carrier accepted after two serial clocks
// - collision accepted after two serial clocks
// - interrupt request is one active-high output
// - address in t1, data t2 to t4
// - 8-bit mode keeps address on high byte
// - upper address valid whole cycle, else floating
// - address 19 in t1, then high
// - bus request raised to obtain mastership
// - attention pulse synchronized, acted on falling edge
// - status codes read 01, write 10, passive 11
// - after reset 8-bit bus, high enable high
`timescale 1ns/1ps
`include "lan_coproc_defines.svh"

module lan_coproc_pins #(
   parameter int DATA_W     = 16,
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic              CLK_SYS_I,
   input  wire logic              NRST_I,
   input  wire logic              CONTROLLER_RESET_IN_I,
   input  wire logic              CHANNEL_ATTENTION_IN_I,
   input  wire logic              TX_BIT_CLOCK_I,
   input  wire logic              RX_BIT_CLOCK_I,
   input  wire logic              SERIAL_RX_IN_I,
   input  wire logic              CARRIER_PRESENT_N_I,
   input  wire logic              COLLISION_N_I,
   input  wire logic              CLEAR_TO_SEND_TIE_I,
   input  wire logic              BUS_MODE_SELECT_I,
   input  wire logic              BUS_GRANT_IN_I,
   input  wire logic [DATA_W-1:0] AD_I,
   output logic [DATA_W-1:0]      AD_O,
   output logic [1:0]             AD_OE_N_O,
   output logic [2:0]             UPPER_ADDR_LOW_GROUP_O,
   output logic [3:0]             UPPER_ADDR_HIGH_GROUP_O,
   output logic                   UPPER_ADDR_OE_N_O,
   output logic                   ADDR19_STATUS_O,
   output logic                   ADDR19_STATUS_OE_N_O,
   output logic [1:0]             CYCLE_STATUS_N_O,
   output logic                   CYCLE_STATUS_OE_N_O,
   output logic                   HIGH_BYTE_ENABLE_N_O,
   output logic                   HIGH_BYTE_ENABLE_OE_N_O,
   output logic                   BUS_REQUEST_OUT_O,
   output logic                   IRQ_OUT_O,
   output logic                   SERIAL_TX_OUT_O,
   output logic                   TX_REQUEST_N_O,
   input  wire logic              IRQ_REQ_I,
   input  wire logic              BUS_CFG_WR_I,
   input  wire logic              BUS16_I,
   input  wire logic              MEM_REQ_I,
   input  wire logic              MEM_WRITE_I,
   input  wire logic [23:0]       MEM_ADDR_I,
   input  wire logic [DATA_W-1:0] MEM_WDATA_I,
   output logic                   MEM_DONE_O,
   output logic [DATA_W-1:0]      MEM_RDATA_O,
   input  wire logic [7:0]        TX_DATA_I,
   input  wire logic              TX_LAST_I,
   input  wire logic              TX_VALID_I,
   output logic                   TX_READY_O,
   output logic                   TX_DONE_O,
   output logic                   COLLISION_O,
   output logic [7:0]             RX_DATA_O,
   output logic                   RX_VALID_O,
   output logic                   RX_END_O,
   output logic                   CARRIER_O,
   output logic                   ACTIVE_O,
   output logic                   INIT_START_O,
   output logic                   ATTENTION_O
);

   // positions in the synchroniser vector
   localparam int I_RST  = 0;
   localparam int I_CA   = 1;
   localparam int I_TXC  = 2;
   localparam int I_RXC  = 3;
   localparam int I_RXD  = 4;
   localparam int I_CRS  = 5;
   localparam int I_CD   = 6;
   localparam int I_CTS  = 7;
   localparam int I_MODE = 8;
   localparam int I_GNT  = 9;
   localparam int SW     = 10 + DATA_W;
   // carrier, collision and clear-to-send idle high
   localparam logic [SW-1:0] SYNC_IDLE = SW'(10'h0e0);

   typedef struct packed {
      logic [SW-1:0]          s1;
      logic [SW-1:0]          s2;
      logic                   ca_d;
      logic                   txc_d;
      logic                   rxc_d;
      logic                   active;
      logic                   bus16;
      lan_coproc_pkg::bus_state_e bus;
      logic                   wr;
      logic [23:0]            addr;
      logic [DATA_W-1:0]      wdata;
      lan_coproc_pkg::tx_state_e tx;
      logic [7:0]             tx_sh;
      logic [2:0]             tx_bit;
      logic [3:0]             pre_cnt;
      logic                   tx_last;
      logic                   started;
      logic                   col_win;
      logic [1:0]             crs_cnt;
      logic [1:0]             cd_cnt;
      logic                   crs_ok;
      logic                   cd_ok;
      logic [7:0]             rx_sh;
      logic [2:0]             rx_bit;
      logic [DATA_W-1:0]      ad;
      logic [1:0]             ad_oe_n;
      logic [6:0]             ua;
      logic                   ua_oe_n;
      logic                   a19;
      logic                   a19_oe_n;
      logic [1:0]             stat;
      logic                   stat_oe_n;
      logic                   bhe_n;
      logic                   bhe_oe_n;
      logic                   req;
      logic                   irq;
      logic                   txd;
      logic                   rts_n;
      logic                   mem_done;
      logic [DATA_W-1:0]      rdata;
      logic                   tx_done;
      logic                   col;
      logic [7:0]             rx_data;
      logic                   rx_valid;
      logic                   rx_end;
      logic                   init;
      logic                   attn;
   } state_s;

   // every bus pin floats, request and interrupt stay low, and the line rests when idle
   function automatic state_s idle_state();
      state_s s;
      s           = '0;
      s.s1        = SYNC_IDLE;
      s.s2        = SYNC_IDLE;
      s.bus       = lan_coproc_pkg::B_IDLE;
      s.tx        = lan_coproc_pkg::TX_IDLE;
      s.ad_oe_n   = 2'h3;
      s.ua        = 7'h7f;
      s.ua_oe_n   = 1'h1;
      s.a19       = 1'h1;
      s.a19_oe_n  = 1'h1;
      s.stat      = `LC_STAT_PASSIVE;
      s.stat_oe_n = 1'h1;
      s.bhe_n     = 1'h1;
      s.bhe_oe_n  = 1'h1;
      s.txd       = `LC_TXD_IDLE;
      s.rts_n     = `LC_RTS_N_IDLE;
      return s;
   endfunction

   function automatic logic fell(input logic prev, input logic cur);
      return prev & ~cur;
   endfunction

   // counts serial clock falls while an active-low input is asserted
   function automatic logic [1:0] qualify(input logic [1:0] cnt,
                                          input logic       in_n,
                                          input logic       edge_seen);
      if (in_n)
         return 2'h0;
      if (edge_seen && cnt != `LC_ACCEPT_EDGES)
         return 2'(cnt + 1'h1);
      return cnt;
   endfunction

   localparam state_s RST_VAL = idle_state();

   state_s     r_r;
   state_s     r_nxt;
   logic [8:0] fifo_data;
   logic       fifo_valid;
   logic       fifo_pop;
   logic       fifo_rdy;

   // transmit bytes queue here; a full queue stalls the byte source
   word_fifo #(
      .WIDTH (9),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_i       (CLK_SYS_I),
      .nrst_i      (NRST_I),
      .in_data_i   ({TX_LAST_I, TX_DATA_I}),
      .in_valid_i  (TX_VALID_I),
      .in_ready_o  (fifo_rdy),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop)
   );

   // one next-state process for all control, serial and bus logic
   always_comb
   begin
      logic txc_fall;
      logic rxc_fall;
      logic ca_fall;
      logic owned;
      logic g;
      txc_fall = 1'h0;
      rxc_fall = 1'h0;
      ca_fall  = 1'h0;
      owned    = 1'h0;
      g        = 1'h0;
      r_nxt    = r_r;
      fifo_pop = 1'h0;

      // pins pass two flops before anything looks at them
      r_nxt.s1 = {AD_I, BUS_GRANT_IN_I, BUS_MODE_SELECT_I,
                  CLEAR_TO_SEND_TIE_I, COLLISION_N_I, CARRIER_PRESENT_N_I,
                  SERIAL_RX_IN_I, RX_BIT_CLOCK_I, TX_BIT_CLOCK_I,
                  CHANNEL_ATTENTION_IN_I, CONTROLLER_RESET_IN_I};
      r_nxt.s2    = r_r.s1;
      r_nxt.ca_d  = r_r.s2[I_CA];
      r_nxt.txc_d = r_r.s2[I_TXC];
      r_nxt.rxc_d = r_r.s2[I_RXC];
      txc_fall    = fell(r_r.txc_d, r_r.s2[I_TXC]);
      rxc_fall    = fell(r_r.rxc_d, r_r.s2[I_RXC]);
      ca_fall     = fell(r_r.ca_d, r_r.s2[I_CA]);
      g           = r_r.s2[I_GNT];

      r_nxt.mem_done = 1'h0;
      r_nxt.tx_done  = 1'h0;
      r_nxt.col      = 1'h0;
      r_nxt.rx_valid = 1'h0;
      r_nxt.rx_end   = 1'h0;
      r_nxt.init     = 1'h0;
      r_nxt.attn     = 1'h0;

      // attention acts on its falling edge; the first one starts init
      if (ca_fall)
      begin
         if (!r_r.active)
         begin
            r_nxt.active = 1'h1;
            r_nxt.init   = 1'h1;
         end
         else
            r_nxt.attn = 1'h1;
      end

      if (BUS_CFG_WR_I)
         r_nxt.bus16 = BUS16_I;
      r_nxt.irq = r_r.active & IRQ_REQ_I;

      // carrier on receive clock, collision on transmit clock
      r_nxt.crs_cnt = qualify(r_r.crs_cnt, r_r.s2[I_CRS], rxc_fall);
      r_nxt.cd_cnt  = qualify(r_r.cd_cnt, r_r.s2[I_CD], txc_fall);
      r_nxt.crs_ok  = (r_nxt.crs_cnt == `LC_ACCEPT_EDGES);
      r_nxt.cd_ok   = (r_nxt.cd_cnt == `LC_ACCEPT_EDGES);

      // receive: lsb first, a byte every eight bits
      if (r_r.active && r_r.crs_ok && rxc_fall)
      begin
         r_nxt.rx_sh  = {r_r.s2[I_RXD], r_r.rx_sh[7:1]};
         r_nxt.rx_bit = 3'(r_r.rx_bit + 1'h1);
         if (r_r.rx_bit == 3'h7)
         begin
            r_nxt.rx_data  = r_nxt.rx_sh;
            r_nxt.rx_valid = 1'h1;
         end
      end
      if (r_r.crs_ok && !r_nxt.crs_ok)
      begin
         r_nxt.rx_end = 1'h1;
         r_nxt.rx_bit = 3'h0;
      end

      // transmit serial unit
      unique case (r_r.tx)
         lan_coproc_pkg::TX_IDLE:
         begin
            // no handshake: the tied-low clear-to-send only gates start
            if (r_r.active && fifo_valid && !r_r.s2[I_CTS])
            begin
               r_nxt.rts_n   = 1'h0;
               r_nxt.tx      = lan_coproc_pkg::TX_PRE;
               r_nxt.tx_sh   = `LC_PREAMBLE_BYTE;
               r_nxt.tx_bit  = 3'h0;
               r_nxt.pre_cnt = 4'h0;
               r_nxt.tx_last = 1'h0;
               r_nxt.started = 1'h0;
               r_nxt.col_win = 1'h0;
            end
         end
         lan_coproc_pkg::TX_PRE,
         lan_coproc_pkg::TX_DATA:
         begin
            if (r_r.col_win && r_r.cd_ok)
            begin
               // abort the frame; the rest of it is flushed unsent
               r_nxt.col   = 1'h1;
               r_nxt.txd   = `LC_TXD_IDLE;
               r_nxt.rts_n = `LC_RTS_N_IDLE;
               r_nxt.tx    = r_r.tx_last ? lan_coproc_pkg::TX_IDLE
                                         : lan_coproc_pkg::TX_DROP;
            end
            else if (txc_fall)
            begin
               r_nxt.txd     = r_r.tx_sh[0];
               r_nxt.started = 1'h1;
               r_nxt.col_win = r_r.started;
               r_nxt.tx_sh   = {1'h0, r_r.tx_sh[7:1]};
               r_nxt.tx_bit  = 3'(r_r.tx_bit + 1'h1);
               if (r_r.tx_bit == 3'h7)
               begin
                  r_nxt.pre_cnt = 4'(r_r.pre_cnt + 1'h1);
                  if (r_r.tx == lan_coproc_pkg::TX_PRE &&
                      r_r.pre_cnt < 4'(`LC_PREAMBLE_BYTES - 4'h1))
                     r_nxt.tx_sh = (r_r.pre_cnt == 4'(`LC_PREAMBLE_BYTES
                        - 4'h2)) ? `LC_SFD_BYTE : `LC_PREAMBLE_BYTE;
                  else if (!r_r.tx_last && fifo_valid)
                  begin
                     fifo_pop      = 1'h1;
                     r_nxt.tx_sh   = fifo_data[7:0];
                     r_nxt.tx_last = fifo_data[8];
                     r_nxt.tx      = lan_coproc_pkg::TX_DATA;
                  end
                  else if (r_r.tx == lan_coproc_pkg::TX_DATA)
                     r_nxt.tx = lan_coproc_pkg::TX_TAIL; // last or underrun
               end
            end
         end
         lan_coproc_pkg::TX_TAIL:
         begin
            // the last bit stands one full bit time before the line rests
            if (txc_fall)
            begin
               r_nxt.txd     = `LC_TXD_IDLE;
               r_nxt.rts_n   = `LC_RTS_N_IDLE;
               r_nxt.tx_done = 1'h1;
               r_nxt.tx      = r_r.tx_last ? lan_coproc_pkg::TX_IDLE
                                           : lan_coproc_pkg::TX_DROP;
            end
         end
         lan_coproc_pkg::TX_DROP:
         begin
            fifo_pop = fifo_valid;
            if (fifo_valid && fifo_data[8])
               r_nxt.tx = lan_coproc_pkg::TX_IDLE;
         end
         default:
            r_nxt.tx = lan_coproc_pkg::TX_IDLE;
      endcase

      // local bus: request, one t1..t4 cycle, then release
      unique case (r_r.bus)
         lan_coproc_pkg::B_IDLE:
         begin
            if (r_r.active && MEM_REQ_I)
            begin
               r_nxt.req = 1'h1;
               r_nxt.bus = lan_coproc_pkg::B_REQ;
            end
         end
         lan_coproc_pkg::B_REQ:
         begin
            if (g)
            begin
               r_nxt.bus   = lan_coproc_pkg::B_T1;
               r_nxt.addr  = MEM_ADDR_I;
               r_nxt.wr    = MEM_WRITE_I;
               r_nxt.wdata = MEM_WDATA_I;
            end
         end
         lan_coproc_pkg::B_T1:
            r_nxt.bus = lan_coproc_pkg::B_T2;
         lan_coproc_pkg::B_T2:
            r_nxt.bus = lan_coproc_pkg::B_T3;
         lan_coproc_pkg::B_T3:
            r_nxt.bus = lan_coproc_pkg::B_T4;
         lan_coproc_pkg::B_T4:
         begin
            // a lost grant at worst finishes this cycle, then leaves
            r_nxt.mem_done = 1'h1;
            r_nxt.rdata    = r_r.bus16 ? r_r.s2[SW-1:10]
                             : DATA_W'(r_r.s2[17:10]);
            r_nxt.req      = 1'h0;
            r_nxt.bus      = lan_coproc_pkg::B_REL;
         end
         lan_coproc_pkg::B_REL:
         begin
            if (!g)
               r_nxt.bus = lan_coproc_pkg::B_IDLE;
         end
         default:
            r_nxt.bus = lan_coproc_pkg::B_IDLE;
      endcase

      // pin drive follows the coming bus state so pins come from flops
      owned = (r_nxt.bus == lan_coproc_pkg::B_T1) ||
              (r_nxt.bus == lan_coproc_pkg::B_T2) ||
              (r_nxt.bus == lan_coproc_pkg::B_T3) ||
              (r_nxt.bus == lan_coproc_pkg::B_T4);
      r_nxt.ad_oe_n   = 2'h3;
      r_nxt.ad        = r_nxt.addr[DATA_W-1:0];
      r_nxt.a19       = 1'h1;
      r_nxt.stat      = `LC_STAT_PASSIVE;
      r_nxt.ua_oe_n   = ~owned | r_r.s2[I_MODE];
      r_nxt.a19_oe_n  = ~owned | r_r.s2[I_MODE];
      r_nxt.stat_oe_n = ~owned;
      r_nxt.bhe_oe_n  = ~owned;
      r_nxt.bhe_n     = ~r_nxt.bus16;
      r_nxt.ua        = owned ? {r_nxt.addr[23:20], r_nxt.addr[18:16]}
                        : 7'h7f;
      if (r_nxt.bus == lan_coproc_pkg::B_T1)
      begin
         r_nxt.ad_oe_n = 2'h0;
         r_nxt.a19     = r_nxt.addr[19];
      end
      else if (owned)
      begin
         // 8-bit bus: high byte keeps the address all cycle
         r_nxt.ad_oe_n = {r_nxt.bus16 & ~r_nxt.wr, ~r_nxt.wr};
         r_nxt.ad      = r_nxt.bus16 ? r_nxt.wdata
                         : {r_nxt.addr[15:8], r_nxt.wdata[7:0]};
      end
      if (r_nxt.bus == lan_coproc_pkg::B_T1 ||
          r_nxt.bus == lan_coproc_pkg::B_T2)
         r_nxt.stat = r_nxt.wr ? `LC_STAT_WRITE : `LC_STAT_READ;

      // controller reset aborts everything, keeping only the synchronisers and the transmit queue
      if (r_r.s2[I_RST])
      begin
         r_nxt       = RST_VAL;
         r_nxt.s1    = r_r.s1;
         r_nxt.s1[I_RST] = CONTROLLER_RESET_IN_I;
         r_nxt.s2    = r_r.s1;
         r_nxt.ca_d  = r_r.s2[I_CA];
         r_nxt.txc_d = r_r.s2[I_TXC];
         r_nxt.rxc_d = r_r.s2[I_RXC];
         fifo_pop    = 1'h0;
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge NRST_I)
   begin
      if (!NRST_I)
         r_r <= RST_VAL;
      else
         r_r <= r_nxt;
   end

   // every port is a state flop, or the fifo's registered ready
   assign AD_O                    = r_r.ad;
   assign AD_OE_N_O               = r_r.ad_oe_n;
   assign UPPER_ADDR_LOW_GROUP_O  = r_r.ua[2:0];
   assign UPPER_ADDR_HIGH_GROUP_O = r_r.ua[6:3];
   assign UPPER_ADDR_OE_N_O       = r_r.ua_oe_n;
   assign ADDR19_STATUS_O         = r_r.a19;
   assign ADDR19_STATUS_OE_N_O    = r_r.a19_oe_n;
   assign CYCLE_STATUS_N_O        = r_r.stat;
   assign CYCLE_STATUS_OE_N_O     = r_r.stat_oe_n;
   assign HIGH_BYTE_ENABLE_N_O    = r_r.bhe_n;
   assign HIGH_BYTE_ENABLE_OE_N_O = r_r.bhe_oe_n;
   assign BUS_REQUEST_OUT_O       = r_r.req;
   assign IRQ_OUT_O               = r_r.irq;
   assign SERIAL_TX_OUT_O         = r_r.txd;
   assign TX_REQUEST_N_O          = r_r.rts_n;
   assign MEM_DONE_O              = r_r.mem_done;
   assign MEM_RDATA_O             = r_r.rdata;
   assign TX_READY_O              = fifo_rdy;
   assign TX_DONE_O               = r_r.tx_done;
   assign COLLISION_O             = r_r.col;
   assign RX_DATA_O               = r_r.rx_data;
   assign RX_VALID_O              = r_r.rx_valid;
   assign RX_END_O                = r_r.rx_end;
   assign CARRIER_O               = r_r.crs_ok;
   assign ACTIVE_O                = r_r.active;
   assign INIT_START_O            = r_r.init;
   assign ATTENTION_O             = r_r.attn;

endmodule // lan_coproc_pins

// ===== tb/lan_coproc_sva.sv
`timescale 1ns/1ps
module lan_coproc_sva (
   input wire logic       CLK_SYS_I,
   input wire logic       NRST_I,
   input wire logic       CONTROLLER_RESET_IN_I,
   input wire logic       TX_BIT_CLOCK_I,
   input wire logic       BUS_GRANT_IN_I,
   input wire logic [1:0] AD_OE_N_O,
   input wire logic       ADDR19_STATUS_O,
   input wire logic       ADDR19_STATUS_OE_N_O,
   input wire logic [1:0] CYCLE_STATUS_N_O,
   input wire logic       BUS_REQUEST_OUT_O,
   input wire logic       IRQ_OUT_O,
   input wire logic       SERIAL_TX_OUT_O,
   input wire logic       TX_REQUEST_N_O,
   input wire logic       ACTIVE_O
);
   // one domain: clock and disable given once
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!NRST_I);
   AST_TXD_IDLE:
   assert property (TX_REQUEST_N_O |-> SERIAL_TX_OUT_O)
      else $error("txd low at rest");
   // a tx clock fall shows on txd four samples later
   AST_TXD_FALL:
   assert property ($changed(SERIAL_TX_OUT_O) && !TX_REQUEST_N_O
      |-> !TX_BIT_CLOCK_I && $past(TX_BIT_CLOCK_I, 4))
      else $error("txd moved off a tx clock fall");
   AST_IDLE:
   assert property (!ACTIVE_O |-> TX_REQUEST_N_O && !BUS_REQUEST_OUT_O
      && !IRQ_OUT_O) else $error("activity before attention");
   AST_RESET:
   assert property ($rose(CONTROLLER_RESET_IN_I) |-> ##[1:10]
      (!ACTIVE_O && AD_OE_N_O == 2'h3)) else $error("reset too slow");
   AST_A19:
   assert property ($fell(ADDR19_STATUS_OE_N_O) |=> ADDR19_STATUS_O[*3])
      else $error("a19 not high after t1");
   AST_OWN:
   assert property (!AD_OE_N_O[0] |-> BUS_REQUEST_OUT_O && BUS_GRANT_IN_I)
      else $error("bus driven without mastership");
   AST_LOSS:
   assert property ($fell(BUS_GRANT_IN_I) |-> ##[0:16] AD_OE_N_O == 2'h3)
      else $error("bus kept after grant loss");
   AST_STAT:
   assert property (CYCLE_STATUS_N_O != 2'h3 |-> CYCLE_STATUS_N_O != 2'h0)
      else $error("unused status code");
endmodule // lan_coproc_sva

// ===== tb/lan_far_side.sv
`timescale 1ns/1ps
// serial chip clocks and a host that grants on request
module lan_far_side (
   input  wire logic req_i,
   output logic      tx_clk_o,
   output logic      rx_clk_o,
   output logic      grant_o
);
   // bit clocks run free at 32 ns, rx offset in phase
   initial
   begin
      {tx_clk_o, rx_clk_o, grant_o} = 3'h6;
      #7;
      forever #16 rx_clk_o = ~rx_clk_o;
   end
   always #16 tx_clk_o = ~tx_clk_o;
   // grant follows request both ways, so request drops first
   always @(req_i) grant_o <= #20 req_i;
endmodule // lan_far_side

// ===== tb/lan_coproc_pins_tb.sv
`timescale 1ns/1ps
module lan_coproc_pins_tb;
   logic CLK_SYS_I, NRST_I, CONTROLLER_RESET_IN_I, CHANNEL_ATTENTION_IN_I;
   logic TX_BIT_CLOCK_I, RX_BIT_CLOCK_I, SERIAL_RX_IN_I, CARRIER_PRESENT_N_I;
   logic COLLISION_N_I, CLEAR_TO_SEND_TIE_I, BUS_MODE_SELECT_I;
   logic BUS_GRANT_IN_I, UPPER_ADDR_OE_N_O, ADDR19_STATUS_O;
   logic [15:0] AD_I, AD_O, MEM_WDATA_I, MEM_RDATA_O, host_d, sr;
   logic [1:0] AD_OE_N_O, CYCLE_STATUS_N_O;
   logic [2:0] UPPER_ADDR_LOW_GROUP_O;
   logic [3:0] UPPER_ADDR_HIGH_GROUP_O;
   logic ADDR19_STATUS_OE_N_O, CYCLE_STATUS_OE_N_O, HIGH_BYTE_ENABLE_N_O;
   logic HIGH_BYTE_ENABLE_OE_N_O, BUS_REQUEST_OUT_O, IRQ_OUT_O;
   logic SERIAL_TX_OUT_O, TX_REQUEST_N_O, IRQ_REQ_I, BUS_CFG_WR_I, BUS16_I;
   logic MEM_REQ_I, MEM_WRITE_I, MEM_DONE_O, TX_LAST_I, TX_VALID_I;
   logic [23:0] MEM_ADDR_I;
   logic [7:0] TX_DATA_I, RX_DATA_O;
   logic TX_READY_O, TX_DONE_O, COLLISION_O, RX_VALID_O, RX_END_O;
   logic CARRIER_O, ACTIVE_O, INIT_START_O, ATTENTION_O;
   int err_count, checks, i;
   lan_coproc_pins dut (.*);
   lan_far_side far (.req_i(BUS_REQUEST_OUT_O), .tx_clk_o(TX_BIT_CLOCK_I),
      .rx_clk_o(RX_BIT_CLOCK_I), .grant_o(BUS_GRANT_IN_I));
   // each data lane shows whoever drives it
   assign AD_I = {AD_OE_N_O[1] ? host_d[15:8] : AD_O[15:8],
      AD_OE_N_O[0] ? host_d[7:0] : AD_O[7:0]};
   initial CLK_SYS_I = 1'h0;
   always #2 CLK_SYS_I = ~CLK_SYS_I;
   task automatic tick(input int n);
      repeat (n) @(posedge CLK_SYS_I);
      #1;
   endtask
   task automatic chk(input string n, input logic [23:0] s, e);
      checks++;
      if (s !== e)
      begin
         err_count++;
         $display("[FAIL] %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // events a wait can name by number
   function automatic logic sel(input int k);
      case (k)
         0: return INIT_START_O;
         1: return !AD_OE_N_O[0];
         2: return MEM_DONE_O;
         3: return !TX_REQUEST_N_O;
         default: return CARRIER_O;
      endcase
   endfunction
   task automatic wait_k(input int k);
      for (int n = 0; n < 500 && sel(k) !== 1'h1; n++)
         tick(1);
      chk($sformatf("wait %0d", k), sel(k), 1'h1);
      if (sel(k) !== 1'h1)
         end_sim();
   endtask
   // one memory cycle; 8-bit mode keeps address on the high lane
   task automatic mem(input logic w, input logic [23:0] a, input [15:0] d);
      {MEM_REQ_I, MEM_WRITE_I, MEM_ADDR_I} = {1'h1, w, a};
      {MEM_WDATA_I, host_d} = {d, d};
      wait_k(1);
      chk("ad t1", AD_O, a[15:0]);
      chk("a19 t1", ADDR19_STATUS_O, a[19]);
      chk("status", CYCLE_STATUS_N_O, w ? 2'h2 : 2'h1);
      chk("ua", {UPPER_ADDR_HIGH_GROUP_O, UPPER_ADDR_LOW_GROUP_O,
         HIGH_BYTE_ENABLE_N_O}, {a[23:20], a[18:16], !BUS16_I});
      tick(1);
      if (w)
         chk("ad t2", AD_O, BUS16_I ? d : {a[15:8], d[7:0]});
      wait_k(2);
      {MEM_REQ_I, host_d} = {1'h0, ~d};
      if (!w)
         chk("rdata", MEM_RDATA_O, BUS16_I ? d : {8'h00, d[7:0]});
      tick(40);
   endtask
   initial
   begin
      {NRST_I, CONTROLLER_RESET_IN_I, CHANNEL_ATTENTION_IN_I} = 3'h0;
      {SERIAL_RX_IN_I, CARRIER_PRESENT_N_I, COLLISION_N_I} = 3'h7;
      {CLEAR_TO_SEND_TIE_I, BUS_MODE_SELECT_I} = 2'h0;
      {IRQ_REQ_I, BUS_CFG_WR_I, BUS16_I, MEM_REQ_I, MEM_WRITE_I} = 5'h0;
      {MEM_ADDR_I, MEM_WDATA_I, host_d, TX_DATA_I, TX_LAST_I, TX_VALID_I} = '0;
      tick(16);
      NRST_I = 1'h1;
      chk("rest", {SERIAL_TX_OUT_O, TX_REQUEST_N_O, AD_OE_N_O, CYCLE_STATUS_N_O,
         HIGH_BYTE_ENABLE_N_O, BUS_REQUEST_OUT_O}, 8'hfe);
      // requests ahead of the first attention stay unanswered
      {MEM_REQ_I, IRQ_REQ_I} = 2'h3;
      tick(20);
      chk("pre attn", {BUS_REQUEST_OUT_O, IRQ_OUT_O, ACTIVE_O}, 3'h0);
      {MEM_REQ_I, CHANNEL_ATTENTION_IN_I} = 2'h1;
      tick(1);
      CHANNEL_ATTENTION_IN_I = 1'h0;
      wait_k(0);
      tick(2);
      chk("irq", {ACTIVE_O, IRQ_OUT_O}, 2'h3);
      IRQ_REQ_I = 1'h0;
      mem(1'h1, 24'ha5c3e1, 16'h1234);
      mem(1'h0, 24'h3f0102, 16'hbeef);
      {BUS_CFG_WR_I, BUS16_I} = 2'h3;
      tick(1);
      BUS_CFG_WR_I = 1'h0;
      mem(1'h1, 24'h080246, 16'hcafe);
      mem(1'h0, 24'hf7fffe, 16'h5a69);
      // one byte frame; keep the last sixteen bits sent
      {TX_DATA_I, TX_LAST_I, TX_VALID_I} = {8'h3c, 2'h3};
      tick(1);
      TX_VALID_I = 1'h0;
      wait_k(3);
      for (i = 0; i < 80 && TX_REQUEST_N_O === 1'h0; i++)
      begin
         @(posedge TX_BIT_CLOCK_I);
         if (TX_REQUEST_N_O === 1'h0)
            sr = {SERIAL_TX_OUT_O, sr[15:1]};
      end
      chk("frame", sr, 16'h3cd5);
      // carrier shorter than a bit clock is refused
      CARRIER_PRESENT_N_I = 1'h0;
      tick(7);
      CARRIER_PRESENT_N_I = 1'h1;
      tick(20);
      chk("glitch", CARRIER_O, 1'h0);
      CARRIER_PRESENT_N_I = 1'h0;
      wait_k(4);
      tick(70);
      chk("rx", RX_DATA_O, 8'hff);
      CARRIER_PRESENT_N_I = 1'h1;
      // controller reset in mid bus cycle
      {MEM_REQ_I, MEM_WRITE_I} = 2'h3;
      wait_k(1);
      CONTROLLER_RESET_IN_I = 1'h1;
      tick(4);
      {CONTROLLER_RESET_IN_I, MEM_REQ_I} = 2'h0;
      tick(6);
      chk("ctl rst", {ACTIVE_O, AD_OE_N_O, BUS_REQUEST_OUT_O}, 4'h6);
      end_sim();
   end
endmodule // lan_coproc_pins_tb
bind lan_coproc_pins lan_coproc_sva u_sva (.*);
